// ===== clkdly_cfg.svh
// Register offsets, field positions and reset values of the output delay block.
`ifndef CLKDLY_CFG_SVH
`define CLKDLY_CFG_SVH

// ==========================================================================
// Register offsets
`define CFG_ADDR_W 12
`define CFG_CTRL_OFS 12'h000
`define CFG_STEP_OFS 12'h004
`define CFG_SYSREF_OFS 12'h008
`define CFG_STATUS_OFS 12'h00c
`define CFG_OUT_BASE 12'h010

// ==========================================================================
// Field positions
`define CFG_MODE_MSB 1
`define CFG_MODE_LSB 0
`define CFG_SRC_MSB 3
`define CFG_SRC_LSB 2
`define CFG_INV_BIT 4
`define CFG_CTRL_W 5
`define CFG_SYSDLY_W 5
`define CFG_HIGH_MSB 3
`define CFG_HIGH_LSB 0
`define CFG_LOW_MSB 7
`define CFG_LOW_LSB 4
`define CFG_DIV_MSB 12
`define CFG_DIV_LSB 8
`define CFG_HS_BIT 13
`define CFG_DYN_BIT 14
`define CFG_PD_BIT 15
`define CFG_BLOCK_BIT 16
`define CFG_OUT_W 17
`define CFG_STAT_SYNC_BIT 16

// ==========================================================================
// Reset values and count limits
`define CFG_CTRL_RST 5'h00
`define CFG_OUT_RST 17'h08844
`define CFG_SRC_PULSOR 2'h2
`define CFG_CNT_MIN 5'h02
`define CFG_CNT_ZERO_AS 5'h10
`define CFG_DIV_MIN 6'h02
`define CFG_DIV_ZERO_AS 6'h20
`define CFG_FIXED_STEPS 1

`endif

// ===== clkdly_pkg.sv
// Types and decode functions shared by the output delay block.
package clkdly_pkg;
`include "clkdly_cfg.svh"

	typedef enum logic [1:0] {
		SYNC_OFF,
		SYNC_PIN,
		SYNC_PIN_DYN,
		SYNC_WRITE_DYN
	} sync_mode_t;

	// A zero field means sixteen; values below the minimum are lifted to it.
	function automatic logic [4:0] count_decode(input logic [3:0] field);
		if (field == 4'h0) return `CFG_CNT_ZERO_AS;
		else if ({1'h0, field} < `CFG_CNT_MIN) return `CFG_CNT_MIN;
		else return {1'h0, field};
	endfunction

	function automatic logic [5:0] div_decode(input logic [4:0] field);
		if (field == 5'h00) return `CFG_DIV_ZERO_AS;
		else if ({1'h0, field} < `CFG_DIV_MIN) return `CFG_DIV_MIN;
		else return {1'h0, field};
	endfunction
endpackage

// ===== delay_channel.sv
// One output divider that can substitute an alternate high/low count per period.
`timescale 1ns/1ps
module delay_channel #(
	parameter int STEP_W = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic hold,
	input wire logic load,
	input wire logic [STEP_W-1:0] load_count,
	input wire logic [5:0] div_len,
	input wire logic [4:0] high_len,
	input wire logic [4:0] low_len,
	input wire logic half_step,
	output logic clk_out,
	output logic half_step_out,
	output logic busy
);
	logic [5:0] cnt_ff, nxt_cnt;
	logic out_ff, nxt_out, alt_ff, nxt_alt, hs_ff, busy_ff, nxt_busy;
	logic [STEP_W-1:0] rem_ff, nxt_rem, eff_rem;
	logic [5:0] cur_hi, cur_len;

	// ======================================================================
	// Period counter
	always_comb begin
		cur_hi = alt_ff ? {1'h0, high_len} : div_len - {1'h0, div_len[5:1]};
		cur_len = alt_ff ? {1'h0, high_len} + {1'h0, low_len} : div_len;
		eff_rem = load ? load_count : rem_ff;
		nxt_cnt = cnt_ff + 6'h01;
		nxt_out = (cnt_ff + 6'h01) < cur_hi;
		nxt_alt = alt_ff;
		nxt_rem = eff_rem;
		if (hold) begin
			// Parked at the last count so the release starts a fresh period.
			nxt_cnt = div_len - 6'h01;
			nxt_out = 1'h0;
			nxt_alt = 1'h0;
			nxt_rem = '0;
		end else if (cnt_ff >= cur_len - 6'h01) begin
			nxt_cnt = 6'h00;
			nxt_out = 1'h1;
			nxt_alt = eff_rem != '0;
			nxt_rem = (eff_rem != '0) ? eff_rem - STEP_W'(1) : eff_rem;
		end
		nxt_busy = nxt_alt | (nxt_rem != '0);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= 6'h00;
			out_ff <= 1'h0;
			alt_ff <= 1'h0;
			rem_ff <= '0;
			hs_ff <= 1'h0;
			busy_ff <= 1'h0;
		end else begin
			cnt_ff <= nxt_cnt;
			out_ff <= nxt_out;
			alt_ff <= nxt_alt;
			rem_ff <= nxt_rem;
			hs_ff <= half_step;
			busy_ff <= nxt_busy;
		end
	end

	assign clk_out = out_ff;
	assign half_step_out = hs_ff;
	assign busy = busy_ff;

	// ======================================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	alt_high_a: assert property (
		(alt_ff && !hold && cnt_ff < {1'h0, high_len}) |-> out_ff)
		else $error("alternate period not high during high count");
	alt_low_a: assert property (
		(alt_ff && !hold && cnt_ff >= {1'h0, high_len}) |-> !out_ff)
		else $error("alternate period not low during low count");
	hold_low_a: assert property (
		hold |=> (!out_ff && !alt_ff)) else $error("output not held low during sync");
	step_dec_a: assert property (
		(!hold && !load && cnt_ff >= cur_len - 6'h01 && rem_ff != '0)
		|=> (alt_ff && rem_ff == $past(rem_ff) - STEP_W'(1)))
		else $error("step count not consumed by substitution");
endmodule

// ===== output_divider_digital_delay.sv
// APB-controlled output dividers with fixed and dynamic digital delay.
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "clkdly_cfg.svh"

// Summary of operation
// - Alternate divide is high count plus low count, each 2..16, total 4..32.
// - Half-step select lets an output shift by half a clock period.
// - Fixed delay applies after sync; affected outputs are held low meanwhile.
// - Dynamic mode substitutes alternate divide once per step on enabled outputs.
// - Larger alternate value delays the output; smaller advances it.
// - Alternate period is high for high count, then low for low count.
// - A zero high or low count field means sixteen.
// - Step count two gives two successive substitutions, doubling the shift.
// - In sync mode 3 a step count write starts the adjustment.
// - Outputs with sync block set ignore sync events.
// - SYSREF timing can be shifted digitally by up to twenty clock cycles.
// - Sync invert picks the pin's active level; toggling it makes an event.
module output_divider_digital_delay #(
	parameter int NUM_OUT = 4,
	parameter int STEP_W = 4,
	parameter int SYSREF_TAPS = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [`CFG_ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sync_pin,
	input wire logic sysref_in,
	output logic [NUM_OUT-1:0] device_clock_output,
	output logic [NUM_OUT-1:0] half_step_out,
	output logic sysref_out
);
	// ======================================================================
	// Declarations
	logic [`CFG_CTRL_W-1:0] ctrl_ff, nxt_ctrl;
	logic [STEP_W-1:0] step_ff, nxt_step;
	logic [`CFG_SYSDLY_W-1:0] sysdly_ff, nxt_sysdly;
	logic [`CFG_OUT_W-1:0] out_cfg_ff [NUM_OUT];
	logic [`CFG_OUT_W-1:0] nxt_out_cfg [NUM_OUT];
	logic [31:0] prdata_ff, nxt_prdata, rd_data;
	logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
	logic step_wr_ff, nxt_step_wr;
	logic access, wr_take, addr_ok;

	logic [2:0] sync_sh_ff, nxt_sync_sh;
	logic sync_stable_ff, nxt_sync_stable, sync_prev_ff, nxt_sync_prev;
	logic sync_level;
	clkdly_pkg::sync_mode_t mode;
	logic dyn_trig, fixed_release;

	logic [2:0] sr_sh_ff, nxt_sr_sh;
	logic sr_stable_ff, nxt_sr_stable;
	logic [SYSREF_TAPS-1:0] sr_line_ff, nxt_sr_line;
	logic sysref_out_ff, nxt_sysref_out;
	logic [SYSREF_TAPS:0] sr_taps;

	logic [NUM_OUT-1:0] hold_vec, load_vec, busy_vec;
	logic [STEP_W-1:0] load_cnt [NUM_OUT];
	logic [5:0] div_len [NUM_OUT];
	logic [4:0] high_len [NUM_OUT];
	logic [4:0] low_len [NUM_OUT];

	// Whether a is the byte address of the configuration word of output i.
	function automatic logic hit_out(input logic [`CFG_ADDR_W-1:0] a, input int i);
		return a == `CFG_OUT_BASE + `CFG_ADDR_W'(4 * i);
	endfunction

	// ======================================================================
	// APB slave
	// One wait state: pready rises in the second access cycle, and writes
	// land at the edge that ends it, so a read never races a write to the same word.
	// Word map: control at 0x000 (sync mode, SYSREF source, sync invert), step
	// count at 0x004, SYSREF delay at 0x008, read-only status at 0x00c, and one
	// configuration word per output from 0x010 upward. An output word holds the
	// high and low counts, the divider, half step, dynamic enable, delay power-down
	// and sync block, in that order from bit 0. Unmapped addresses answer with
	// pslverr and never change state; writes to the status word are dropped.
	assign access = psel && penable;
	assign wr_take = access && pready_ff && pwrite;

	always_comb begin
		addr_ok = (paddr == `CFG_CTRL_OFS) || (paddr == `CFG_STEP_OFS) ||
			(paddr == `CFG_SYSREF_OFS) || (paddr == `CFG_STATUS_OFS);
		for (int i = 0; i < NUM_OUT; i++) begin
			if (hit_out(paddr, i)) addr_ok = 1'h1;
		end
	end

	always_comb begin
		rd_data = 32'h0000_0000;
		if (paddr == `CFG_CTRL_OFS) rd_data[`CFG_CTRL_W-1:0] = ctrl_ff;
		if (paddr == `CFG_STEP_OFS) rd_data[STEP_W-1:0] = step_ff;
		if (paddr == `CFG_SYSREF_OFS) rd_data[`CFG_SYSDLY_W-1:0] = sysdly_ff;
		if (paddr == `CFG_STATUS_OFS) begin
			rd_data[NUM_OUT-1:0] = busy_vec;
			rd_data[`CFG_STAT_SYNC_BIT] = sync_level;
		end
		for (int i = 0; i < NUM_OUT; i++) begin
			if (hit_out(paddr, i)) rd_data[`CFG_OUT_W-1:0] = out_cfg_ff[i];
		end
	end

	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_step = step_ff;
		nxt_sysdly = sysdly_ff;
		nxt_out_cfg = out_cfg_ff;
		nxt_step_wr = 1'h0;
		nxt_pready = access && !pready_ff;
		nxt_pslverr = access && !pready_ff && !addr_ok;
		nxt_prdata = prdata_ff;
		if (access && !pready_ff) nxt_prdata = (pwrite || !addr_ok) ? 32'h0000_0000 : rd_data;
		if (wr_take && addr_ok) begin
			if (paddr == `CFG_CTRL_OFS) nxt_ctrl = pwdata[`CFG_CTRL_W-1:0];
			if (paddr == `CFG_STEP_OFS) begin
				nxt_step = pwdata[STEP_W-1:0];
				nxt_step_wr = 1'h1;
			end
			if (paddr == `CFG_SYSREF_OFS) begin
				// Delays beyond the tap line are clamped rather than wrapped.
				nxt_sysdly = (pwdata[`CFG_SYSDLY_W-1:0] > `CFG_SYSDLY_W'(SYSREF_TAPS)) ?
					`CFG_SYSDLY_W'(SYSREF_TAPS) : pwdata[`CFG_SYSDLY_W-1:0];
			end
			for (int i = 0; i < NUM_OUT; i++) begin
				if (hit_out(paddr, i)) nxt_out_cfg[i] = pwdata[`CFG_OUT_W-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= `CFG_CTRL_RST;
			step_ff <= '0;
			sysdly_ff <= '0;
			for (int i = 0; i < NUM_OUT; i++) out_cfg_ff[i] <= `CFG_OUT_RST;
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'h0;
			pslverr_ff <= 1'h0;
			step_wr_ff <= 1'h0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			step_ff <= nxt_step;
			sysdly_ff <= nxt_sysdly;
			out_cfg_ff <= nxt_out_cfg;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
			step_wr_ff <= nxt_step_wr;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	// ======================================================================
	// Sync input
	// A pin change counts only once the second and third stages agree.
	// The edge detector starts from the idle level, so leaving reset is never
	// taken for a sync event; toggling sync invert flips the level and makes one.
	always_comb begin
		nxt_sync_sh = {sync_sh_ff[1:0], sync_pin};
		nxt_sync_stable = (sync_sh_ff[2] == sync_sh_ff[1]) ? sync_sh_ff[2] : sync_stable_ff;
		nxt_sync_prev = sync_level;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_sh_ff <= 3'h0;
			sync_stable_ff <= 1'h0;
			sync_prev_ff <= 1'h0;
		end else begin
			sync_sh_ff <= nxt_sync_sh;
			sync_stable_ff <= nxt_sync_stable;
			sync_prev_ff <= nxt_sync_prev;
		end
	end

	assign sync_level = sync_stable_ff ^ ctrl_ff[`CFG_INV_BIT];
	assign mode = clkdly_pkg::sync_mode_t'(ctrl_ff[`CFG_MODE_MSB:`CFG_MODE_LSB]);

	// ======================================================================
	// Channel control
	// A blocked output sees neither the hold nor the load. An output whose delay
	// is powered down is still held low in fixed mode but skips the substitution,
	// so after the release it only restarts in step with its own divider.
	always_comb begin
		fixed_release = (mode == clkdly_pkg::SYNC_PIN) && sync_prev_ff && !sync_level;
		dyn_trig = ((mode == clkdly_pkg::SYNC_PIN_DYN) && sync_level && !sync_prev_ff &&
			(ctrl_ff[`CFG_SRC_MSB:`CFG_SRC_LSB] == `CFG_SRC_PULSOR)) ||
			((mode == clkdly_pkg::SYNC_WRITE_DYN) && step_wr_ff);
		for (int i = 0; i < NUM_OUT; i++) begin
			hold_vec[i] = (mode == clkdly_pkg::SYNC_PIN) && sync_level &&
				!out_cfg_ff[i][`CFG_BLOCK_BIT];
			load_vec[i] = !out_cfg_ff[i][`CFG_BLOCK_BIT] && !out_cfg_ff[i][`CFG_PD_BIT] &&
				(fixed_release || (dyn_trig && out_cfg_ff[i][`CFG_DYN_BIT]));
			load_cnt[i] = fixed_release ? STEP_W'(`CFG_FIXED_STEPS) : step_ff;
			high_len[i] = clkdly_pkg::count_decode(out_cfg_ff[i][`CFG_HIGH_MSB:`CFG_HIGH_LSB]);
			low_len[i] = clkdly_pkg::count_decode(out_cfg_ff[i][`CFG_LOW_MSB:`CFG_LOW_LSB]);
			div_len[i] = clkdly_pkg::div_decode(out_cfg_ff[i][`CFG_DIV_MSB:`CFG_DIV_LSB]);
		end
	end

	for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
		delay_channel #(
			.STEP_W(STEP_W)
		) i_delay_channel (
			.pclk(pclk),
			.presetn(presetn),
			.hold(hold_vec[g]),
			.load(load_vec[g]),
			.load_count(load_cnt[g]),
			.div_len(div_len[g]),
			.high_len(high_len[g]),
			.low_len(low_len[g]),
			.half_step(out_cfg_ff[g][`CFG_HS_BIT]),
			.clk_out(device_clock_output[g]),
			.half_step_out(half_step_out[g]),
			.busy(busy_vec[g])
		);
	end

	// ======================================================================
	// SYSREF delay line
	// The tap line is only as long as the largest delay; a larger request is
	// clamped on write, so the tap index never leaves the line.
	always_comb begin
		nxt_sr_sh = {sr_sh_ff[1:0], sysref_in};
		nxt_sr_stable = (sr_sh_ff[2] == sr_sh_ff[1]) ? sr_sh_ff[2] : sr_stable_ff;
		nxt_sr_line = {sr_line_ff[SYSREF_TAPS-2:0], sr_stable_ff};
		sr_taps = {sr_line_ff, sr_stable_ff};
		nxt_sysref_out = sr_taps[sysdly_ff];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sr_sh_ff <= 3'h0;
			sr_stable_ff <= 1'h0;
			sr_line_ff <= '0;
			sysref_out_ff <= 1'h0;
		end else begin
			sr_sh_ff <= nxt_sr_sh;
			sr_stable_ff <= nxt_sr_stable;
			sr_line_ff <= nxt_sr_line;
			sysref_out_ff <= nxt_sysref_out;
		end
	end

	assign sysref_out = sysref_out_ff;

	// ======================================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Bus side: one answer per access, and refused writes leave no trace; then sync mode off neither holds nor loads.
	apb_wait_a: assert property (
		(access && !pready_ff) |=> pready_ff) else $error("pready missing after access");
	apb_release_a: assert property (
		pready_ff |=> !pready_ff) else $error("pready held longer than one cycle");
	ready_cause_a: assert property (
		pready_ff |-> $past(access)) else $error("pready without an access");
	err_pulse_a: assert property (
		pslverr_ff |-> pready_ff) else $error("error flag without ready");
	write_rdata_a: assert property (
		(pready_ff && pwrite) |-> prdata_ff == 32'h0000_0000)
		else $error("write returned read data");
	unmapped_write_a: assert property (
		(wr_take && !addr_ok) |=> ($stable(ctrl_ff) && $stable(step_ff) && $stable(sysdly_ff)))
		else $error("unmapped write changed a register");
	ctrl_write_a: assert property (
		(wr_take && paddr == `CFG_CTRL_OFS) |=> ctrl_ff == $past(pwdata[`CFG_CTRL_W-1:0]))
		else $error("control write lost");
	step_capture_a: assert property (
		(wr_take && paddr == `CFG_STEP_OFS) |=>
		(step_wr_ff && step_ff == $past(pwdata[STEP_W-1:0]))) else $error("step write lost");
	mode_off_a: assert property (
		(mode == clkdly_pkg::SYNC_OFF) |-> (hold_vec == '0 && load_vec == '0))
		else $error("sync acted while disabled");

	// Input filters: the filtered level moves only when two stages agree; then the output 0 count range, the SYSREF delay range and the delay tap.
	sync_filter_a: assert property (
		(sync_sh_ff[2] != sync_sh_ff[1]) |=> $stable(sync_stable_ff))
		else $error("sync glitch passed the filter");
	sync_agree_a: assert property (
		(sync_sh_ff[2] == sync_sh_ff[1]) |=> sync_stable_ff == $past(sync_sh_ff[2]))
		else $error("sync level not taken");
	sr_filter_a: assert property (
		(sr_sh_ff[2] != sr_sh_ff[1]) |=> $stable(sr_stable_ff))
		else $error("sysref glitch passed the filter");
	sr_agree_a: assert property (
		(sr_sh_ff[2] == sr_sh_ff[1]) |=> sr_stable_ff == $past(sr_sh_ff[2]))
		else $error("sysref level not taken");
	count_range_a: assert property (
		(high_len[0] >= 5'h02 && high_len[0] <= 5'h10 && low_len[0] >= 5'h02 &&
		low_len[0] <= 5'h10)) else $error("alternate count out of range");
	sysref_range_a: assert property (
		sysdly_ff <= `CFG_SYSDLY_W'(SYSREF_TAPS)) else $error("sysref delay beyond limit");
	sysref_tap_a: assert property (
		(sysdly_ff == 5'h02 && $stable(sysdly_ff)) |=> sysref_out_ff == $past(sr_stable_ff, 3))
		else $error("sysref delay tap wrong");

	// Per output: every channel is checked, not only the first.
	for (genvar g = 0; g < NUM_OUT; g++) begin : g_chk
		block_ignore_a: assert property (
			out_cfg_ff[g][`CFG_BLOCK_BIT] |-> (!hold_vec[g] && !load_vec[g]))
			else $error("blocked output reacted to sync");
		step_write_a: assert property (
			(wr_take && paddr == `CFG_STEP_OFS && mode == clkdly_pkg::SYNC_WRITE_DYN &&
			!out_cfg_ff[g][`CFG_BLOCK_BIT] && !out_cfg_ff[g][`CFG_PD_BIT] &&
			out_cfg_ff[g][`CFG_DYN_BIT] && $stable(ctrl_ff) ##1 $stable(out_cfg_ff[g]))
			|-> (load_vec[g] && load_cnt[g] == step_ff))
			else $error("step write did not start delay");
		sync_hold_a: assert property (
			(mode == clkdly_pkg::SYNC_PIN && sync_level && !out_cfg_ff[g][`CFG_BLOCK_BIT])
			|=> !device_clock_output[g]) else $error("output not low during sync");
		zero_count_a: assert property (
			(out_cfg_ff[g][`CFG_HIGH_MSB:`CFG_HIGH_LSB] == 4'h0) |-> high_len[g] == 5'h10)
			else $error("zero count not read as sixteen");
		zero_low_a: assert property (
			(out_cfg_ff[g][`CFG_LOW_MSB:`CFG_LOW_LSB] == 4'h0) |-> low_len[g] == 5'h10)
			else $error("zero low count not read as sixteen");
		dyn_gate_a: assert property (
			(dyn_trig && !out_cfg_ff[g][`CFG_DYN_BIT]) |-> !load_vec[g])
			else $error("output without dynamic enable was adjusted");
		pd_gate_a: assert property (
			out_cfg_ff[g][`CFG_PD_BIT] |-> !load_vec[g]) else $error("powered-down delay loaded");
		half_step_a: assert property (
			half_step_out[g] == $past(out_cfg_ff[g][`CFG_HS_BIT])) else $error("half step lost");
		out_write_a: assert property (
			(wr_take && hit_out(paddr, g)) |=> out_cfg_ff[g] == $past(pwdata[`CFG_OUT_W-1:0]))
			else $error("output word write lost");
	end
endmodule

// ===== clock_receiver.sv
// Receiver model that measures run lengths and rising edges of each delayed clock.
`timescale 1ns/1ps
module clock_receiver #(
	parameter int NUM_OUT = 4
) (
	input wire logic pclk,
	input wire logic [NUM_OUT-1:0] clk_in,
	input wire logic clear,
	output logic [NUM_OUT-1:0][31:0] rise_cyc,
	output logic [NUM_OUT-1:0][7:0] max_high,
	output logic [NUM_OUT-1:0][7:0] max_low,
	output logic [NUM_OUT-1:0][7:0] min_low
);
	// ==========================================================================
	// Run measurement
	// The run that straddles a clear is dropped, because its start was never seen.
	logic [NUM_OUT-1:0] prev_lvl = '0;
	logic [NUM_OUT-1:0] armed = '0;
	logic [NUM_OUT-1:0][7:0] run = '0;
	logic [31:0] cyc = 32'h0;
	initial begin
		rise_cyc = '0;
		max_high = '0;
		max_low = '0;
		min_low = '1;
	end
	always @(posedge pclk) begin
		cyc = cyc + 32'h1;
		for (int i = 0; i < NUM_OUT; i++) begin
			if (clear) begin
				armed[i] = 1'h0;
				max_high[i] = 8'h0;
				max_low[i] = 8'h0;
				min_low[i] = 8'hff;
			end
			if (clk_in[i] !== prev_lvl[i]) begin
				if (armed[i] && prev_lvl[i] && run[i] > max_high[i]) max_high[i] = run[i];
				if (armed[i] && !prev_lvl[i] && run[i] > max_low[i]) max_low[i] = run[i];
				if (armed[i] && !prev_lvl[i] && run[i] < min_low[i]) min_low[i] = run[i];
				if (clk_in[i] === 1'h1) rise_cyc[i] = cyc;
				armed[i] = !clear;
				run[i] = 8'h1;
			end else if (run[i] != 8'hff) begin
				run[i] = run[i] + 8'h1;
			end
			prev_lvl[i] = clk_in[i];
		end
	end
endmodule

// ===== tb_output_divider_digital_delay.sv
// Self-checking testbench for the output divider with digital delay.
`timescale 1ns/1ps
`include "clkdly_cfg.svh"
module tb_output_divider_digital_delay;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sync_pin = 1'h0;
	logic sysref_in = 1'h0;
	logic [3:0] device_clock_output;
	logic [3:0] half_step_out;
	logic sysref_out;
	logic clear = 1'h0;
	logic [3:0][31:0] rise_cyc;
	logic [3:0][7:0] max_high;
	logic [3:0][7:0] max_low;
	logic [3:0][7:0] min_low;
	logic [31:0] r;
	logic e;
	int mismatches = 0;
	int check_count = 0;

	always #5 pclk = ~pclk;

	output_divider_digital_delay #(.NUM_OUT(4), .STEP_W(4), .SYSREF_TAPS(20))
		i_output_divider_digital_delay (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sync_pin(sync_pin), .sysref_in(sysref_in),
		.device_clock_output(device_clock_output), .half_step_out(half_step_out),
		.sysref_out(sysref_out));
	clock_receiver #(.NUM_OUT(4)) i_clock_receiver (.pclk(pclk),
		.clk_in(device_clock_output), .clear(clear), .rise_cyc(rise_cyc),
		.max_high(max_high), .max_low(max_low), .min_low(min_low));

	// ==========================================================================
	// Shared tasks
	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (n >= 20) begin
			mismatches++;
			conclude();
		end
	endtask
	task automatic settle();
		int n;
		n = 0;
		do begin
			apb(1'h0, `CFG_STATUS_OFS, 32'h0);
			n++;
		end while (r[3:0] !== 4'h0 && n < 50);
		if (r[3:0] !== 4'h0) begin
			mismatches++;
			conclude();
		end
		repeat (40) @(posedge pclk);
	endtask
	task automatic clr();
		@(posedge pclk);
		clear <= 1'h1;
		@(posedge pclk);
		clear <= 1'h0;
	endtask
	// Phase of an output against output 0, in clock cycles modulo the divider of 8.
	function automatic logic [31:0] phase(input int i);
		return 32'((((int'(rise_cyc[i]) - int'(rise_cyc[0])) % 8) + 8) % 8);
	endfunction
	task automatic step(input logic [31:0] n);
		apb(1'h1, `CFG_STEP_OFS, n);
		settle();
	endtask

	// ==========================================================================
	// Scenarios
	task automatic t_reset_map();
		apb(1'h0, `CFG_CTRL_OFS, 32'h0);
		chk(r, 32'h0);
		apb(1'h0, `CFG_STEP_OFS, 32'h0);
		chk(r, 32'h0);
		for (int i = 0; i < 4; i++) begin
			apb(1'h0, `CFG_OUT_BASE + 12'(4 * i), 32'h0);
			chk(r, 32'h00008844);
		end
		apb(1'h0, 12'h100, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		apb(1'h1, 12'h100, 32'h5);
		chk({31'h0, e}, 32'h1);
		apb(1'h1, `CFG_STATUS_OFS, 32'hffffffff);
		apb(1'h0, `CFG_STATUS_OFS, 32'h0);
		chk(r, 32'h0);
	endtask
	task automatic t_dyn_write();
		apb(1'h1, `CFG_OUT_BASE + 12'h004, 32'h00006854);
		apb(1'h1, `CFG_OUT_BASE + 12'h008, 32'h00004800);
		apb(1'h1, `CFG_OUT_BASE + 12'h00c, 32'h00018844);
		chk({28'h0, half_step_out}, 32'h2);
		apb(1'h1, `CFG_CTRL_OFS, 32'h3);
		clr();
		step(32'h1);
		chk(phase(1), 32'h1);
		chk({24'h0, max_high[1]}, 32'h4);
		chk({24'h0, max_low[1]}, 32'h5);
		chk({24'h0, max_high[2]}, 32'h10);
		chk({24'h0, max_low[2]}, 32'h10);
		chk(phase(2), 32'h0);
		step(32'h2);
		chk(phase(1), 32'h3);
	endtask
	task automatic t_advance();
		apb(1'h1, `CFG_OUT_BASE + 12'h008, 32'h00004832);
		clr();
		step(32'h1);
		chk(phase(2), 32'h5);
		chk({24'h0, min_low[2]}, 32'h3);
		chk(phase(1), 32'h4);
	endtask
	task automatic t_dyn_pin();
		apb(1'h1, `CFG_CTRL_OFS, 32'h0000000a);
		step(32'h1);
		chk(phase(1), 32'h4);
		@(posedge pclk);
		sync_pin <= 1'h1;
		repeat (12) @(posedge pclk);
		sync_pin <= 1'h0;
		settle();
		chk(phase(1), 32'h5);
	endtask
	task automatic t_fixed();
		logic [31:0] rise3;
		apb(1'h1, `CFG_CTRL_OFS, 32'h1);
		clr();
		apb(1'h1, `CFG_CTRL_OFS, 32'h11);
		repeat (8) @(posedge pclk);
		apb(1'h0, `CFG_STATUS_OFS, 32'h0);
		chk({31'h0, r[16]}, 32'h1);
		rise3 = rise_cyc[3];
		repeat (10) begin
			@(posedge pclk);
			#1;
			chk({29'h0, device_clock_output[2:0]}, 32'h0);
		end
		chk({31'h0, rise_cyc[3] != rise3}, 32'h1);
		chk({24'h0, max_low[3]}, 32'h4);
		chk({24'h0, min_low[3]}, 32'h4);
		clr();
		apb(1'h1, `CFG_CTRL_OFS, 32'h1);
		settle();
		chk({24'h0, max_low[1]}, 32'h5);
		chk({24'h0, max_high[1]}, 32'h4);
		apb(1'h1, `CFG_OUT_BASE + 12'h004, 32'h00016854);
	endtask
	task automatic t_sysref(input logic [31:0] d, input logic [31:0] exp);
		int n;
		n = 0;
		apb(1'h1, `CFG_SYSREF_OFS, d);
		@(posedge pclk);
		sysref_in <= 1'h1;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (sysref_out !== 1'h1 && n < 64);
		chk(32'(n), exp);
		@(posedge pclk);
		sysref_in <= 1'h0;
		repeat (40) @(posedge pclk);
	endtask

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		t_reset_map();
		t_dyn_write();
		t_advance();
		t_dyn_pin();
		t_fixed();
		t_sysref(32'h2, 32'h7);
		t_sysref(32'h14, 32'h19);
		t_sysref(32'h19, 32'h19);
		conclude();
	end
endmodule
